//--- prescale_tick.sv
`timescale 1ns/100ps
`default_nettype none
// Power-of-two prescaler; held clear while stopped so the first tick is a full period
module prescale_tick (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // Control
  input  wire logic       run,
  input  wire logic [3:0] exp_sel,
  // Tick
  output logic            tick
);

  logic [8:0] cnt_q;
  logic [8:0] cnt_d;
  logic [8:0] mask;

  assign mask  = 9'((10'h001 << exp_sel) - 10'h001);
  assign cnt_d = run ? 9'(cnt_q + 9'h001) : 9'h000;
  assign tick  = run && ((cnt_q & mask) == mask);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cnt_q <= 9'h000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule // prescale_tick
`default_nettype wire

//--- quad_timer_counter_unit.sv
`timescale 1ns/100ps
`default_nettype none
module quad_timer_counter_unit (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       nrst,
  // Units 0 and 1 configuration
  input  wire logic [7:0]                 timer_mode_reg,
  input  wire logic [7:0]                 clock_control_reg,
  input  wire logic                       unit0_run,
  input  wire logic                       unit1_run,
  // Units 0 and 1 count access
  input  wire timer_unit_pkg::byte_write_s unit0_count_wr,
  input  wire timer_unit_pkg::byte_write_s unit1_count_wr,
  output logic [7:0]                      unit0_count_high,
  output logic [7:0]                      unit0_count_low,
  output logic [7:0]                      unit1_count_high,
  output logic [7:0]                      unit1_count_low,
  // Units 0 and 1 flags
  input  wire logic                       unit0_overflow_clear,
  input  wire logic                       unit1_overflow_clear,
  output logic                            unit0_overflow_flag,
  output logic                            unit1_overflow_flag,
  // Shared event / toggle pins
  input  wire logic                       unit0_event_pin_in,
  output logic                            unit0_event_pin_out,
  output logic                            unit0_event_pin_oe,
  input  wire logic                       unit1_event_pin_in,
  output logic                            unit1_event_pin_out,
  output logic                            unit1_event_pin_oe,
  // Unit 2 control
  input  wire logic [7:0]                 unit2_control_reg,
  input  wire logic [2:0]                 unit2_prescale_select,
  input  wire timer_unit_pkg::byte_write_s unit2_count_wr,
  input  wire timer_unit_pkg::byte_write_s unit2_cmp_reload_wr,
  output logic [7:0]                      unit2_count_high,
  output logic [7:0]                      unit2_count_low,
  output logic [7:0]                      unit2_cmp_reload_high,
  output logic [7:0]                      unit2_cmp_reload_low,
  // Unit 2 flags
  input  wire logic                       unit2_flag_clear,
  output logic                            unit2_overflow_flag,
  output logic                            unit2_compare_flag,
  // Unit 2 capture
  input  wire logic [2:0]                 capture_pin_in,
  input  wire logic [2:0]                 capture_flag_clear,
  output logic [2:0]                      capture_flag,
  output logic [7:0]                      capture0_high,
  output logic [7:0]                      capture0_low,
  output logic [7:0]                      capture1_high,
  output logic [7:0]                      capture1_low,
  output logic [7:0]                      capture2_high,
  output logic [7:0]                      capture2_low,
  // Unit 3
  input  wire logic [7:0]                 unit3_control_reg,
  input  wire logic [7:0]                 extended_irq_enable_reg,
  input  wire timer_unit_pkg::byte_write_s unit3_reload_wr,
  input  wire logic                       unit3_irq_ack,
  output logic [7:0]                      unit3_reload_high,
  output logic [7:0]                      unit3_reload_low,
  output logic                            unit3_overflow_flag,
  output logic                            unit3_irq_req,
  output logic                            unit3_baud_tick
);

  // Pin synchronisers: units 0/1 event pins, then capture pins
  logic [timer_unit_pkg::PIN_COUNT-1:0] pin_raw;
  logic [timer_unit_pkg::PIN_COUNT-1:0] sync1_q;
  logic [timer_unit_pkg::PIN_COUNT-1:0] sync2_q;
  logic [timer_unit_pkg::PIN_COUNT-1:0] sync3_q;
  logic [timer_unit_pkg::PIN_COUNT-1:0] pin_fall;

  assign pin_raw = {capture_pin_in, unit1_event_pin_in, unit0_event_pin_in};

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sync1_q <= '1;
      sync2_q <= '1;
      sync3_q <= '1;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  assign pin_fall = sync3_q & ~sync2_q;

  // Shared divide-by-12 tick for standard timer rate
  logic [3:0] div12_q;
  logic       div12_tick;

  assign div12_tick = (div12_q == timer_unit_pkg::DIV12_LAST);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      div12_q <= 4'h0;
    end else begin
      div12_q <= div12_tick ? 4'h0 : 4'(div12_q + 4'h1);
    end
  end

  // Units 0 and 1
  timer_unit_pkg::byte_write_s u01_wr [2];
  logic [1:0]  u01_run;
  logic [1:0]  u01_ct;
  logic [1:0]  u01_divsel;
  logic [1:0]  u01_togoe;
  logic [1:0]  u01_clear;
  logic [15:0] u01_cnt_q [2];
  logic [1:0]  u01_flag_q;
  logic [1:0]  u01_tog_q;
  logic [1:0]  u01_ovf;

  assign u01_wr[0]  = unit0_count_wr;
  assign u01_wr[1]  = unit1_count_wr;
  assign u01_run    = {unit1_run, unit0_run};
  assign u01_ct     = {timer_mode_reg[timer_unit_pkg::MODE_CT_BIT1], timer_mode_reg[timer_unit_pkg::MODE_CT_BIT0]};
  assign u01_divsel = {clock_control_reg[timer_unit_pkg::CKC_DIVSEL_BIT1],
                       clock_control_reg[timer_unit_pkg::CKC_DIVSEL_BIT0]};
  assign u01_togoe  = {clock_control_reg[timer_unit_pkg::CKC_TOGOE_BIT1],
                       clock_control_reg[timer_unit_pkg::CKC_TOGOE_BIT0]};
  assign u01_clear  = {unit1_overflow_clear, unit0_overflow_clear};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_unit
      logic        src_tick;
      logic        step;
      logic [15:0] cnt_d;

      assign src_tick   = u01_ct[g] ? pin_fall[g] : (u01_divsel[g] ? 1'b1 : div12_tick);
      assign step       = u01_run[g] && src_tick;
      assign u01_ovf[g] = step && (u01_cnt_q[g] == timer_unit_pkg::MAX_COUNT);
      // byte halves, writes win over counting
      assign cnt_d = (u01_wr[g].wr_high || u01_wr[g].wr_low) ?
                     {u01_wr[g].wr_high ? u01_wr[g].data : u01_cnt_q[g][15:8],
                      u01_wr[g].wr_low  ? u01_wr[g].data : u01_cnt_q[g][7:0]} :
                     (step ? 16'(u01_cnt_q[g] + 16'h0001) : u01_cnt_q[g]);

      always_ff @(posedge ref_clk) begin
        if (!nrst) begin
          u01_cnt_q[g]  <= timer_unit_pkg::COUNT_RST;
          u01_flag_q[g] <= 1'b0;
          u01_tog_q[g]  <= 1'b1;
        end else begin
          u01_cnt_q[g]  <= cnt_d;
          u01_flag_q[g] <= u01_ovf[g] || (u01_flag_q[g] && !u01_clear[g]);
          u01_tog_q[g]  <= !u01_togoe[g] ? 1'b1 : (u01_ovf[g] ? !u01_tog_q[g] : u01_tog_q[g]);
        end
      end
    end
  endgenerate

  assign unit0_count_high    = u01_cnt_q[0][15:8];
  assign unit0_count_low     = u01_cnt_q[0][7:0];
  assign unit1_count_high    = u01_cnt_q[1][15:8];
  assign unit1_count_low     = u01_cnt_q[1][7:0];
  assign unit0_overflow_flag = u01_flag_q[0];
  assign unit1_overflow_flag = u01_flag_q[1];
  assign unit0_event_pin_out = u01_tog_q[0];
  assign unit0_event_pin_oe  = u01_togoe[0];
  assign unit1_event_pin_out = u01_tog_q[1];
  assign unit1_event_pin_oe  = u01_togoe[1];

  // Unit 2
  logic        u2_run;
  logic        u2_tick;
  logic        u2_step;
  logic        u2_ovf;
  logic        u2_match;
  logic [15:0] u2_cnt_q;
  logic [15:0] u2_cnt_d;
  logic [15:0] u2_cmp_q;
  logic [15:0] u2_cmp_d;
  logic        u2_ovf_q;
  logic        u2_cmp_flag_q;

  assign u2_run = unit2_control_reg[timer_unit_pkg::U2_RUN_BIT];

  prescale_tick u_u2_prescale (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .run     (u2_run),
    .exp_sel (timer_unit_pkg::U2_PS_EXP[unit2_prescale_select]),
    .tick    (u2_tick)
  );

  assign u2_step  = u2_run && u2_tick;
  assign u2_ovf   = u2_step && (u2_cnt_q == timer_unit_pkg::MAX_COUNT);
  // equality checked as the count advances
  assign u2_match = u2_step && !unit2_control_reg[timer_unit_pkg::U2_CMRL_BIT] && (u2_cnt_q == u2_cmp_q);

  assign u2_cnt_d = (unit2_count_wr.wr_high || unit2_count_wr.wr_low) ?
                    {unit2_count_wr.wr_high ? unit2_count_wr.data : u2_cnt_q[15:8],
                     unit2_count_wr.wr_low  ? unit2_count_wr.data : u2_cnt_q[7:0]} :
                    (u2_ovf && unit2_control_reg[timer_unit_pkg::U2_CMRL_BIT]) ? u2_cmp_q :
                    (u2_step ? 16'(u2_cnt_q + 16'h0001) : u2_cnt_q);
  assign u2_cmp_d = {unit2_cmp_reload_wr.wr_high ? unit2_cmp_reload_wr.data : u2_cmp_q[15:8],
                     unit2_cmp_reload_wr.wr_low  ? unit2_cmp_reload_wr.data : u2_cmp_q[7:0]};

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      u2_cnt_q      <= timer_unit_pkg::COUNT_RST;
      u2_cmp_q      <= timer_unit_pkg::COUNT_RST;
      u2_ovf_q      <= 1'b0;
      u2_cmp_flag_q <= 1'b0;
    end else begin
      u2_cnt_q      <= u2_cnt_d;
      u2_cmp_q      <= u2_cmp_d;
      u2_ovf_q      <= u2_ovf || (u2_ovf_q && !unit2_flag_clear);
      u2_cmp_flag_q <= u2_match || (u2_cmp_flag_q && !unit2_flag_clear);
    end
  end

  assign unit2_count_high      = u2_cnt_q[15:8];
  assign unit2_count_low       = u2_cnt_q[7:0];
  assign unit2_cmp_reload_high = u2_cmp_q[15:8];
  assign unit2_cmp_reload_low  = u2_cmp_q[7:0];
  assign unit2_overflow_flag   = u2_ovf_q;
  assign unit2_compare_flag    = u2_cmp_flag_q;

  // Capture channels snapshot the live count on a falling pin edge
  logic [15:0] cap_q [3];
  logic [2:0]  cap_flag_q;
  logic [2:0]  cap_edge;

  assign cap_edge = pin_fall[4:2];

  generate
    for (g = 0; g < 3; g++) begin : g_capture
      always_ff @(posedge ref_clk) begin
        if (!nrst) begin
          cap_q[g]      <= timer_unit_pkg::COUNT_RST;
          cap_flag_q[g] <= 1'b0;
        end else begin
          cap_q[g]      <= cap_edge[g] ? u2_cnt_q : cap_q[g];
          cap_flag_q[g] <= cap_edge[g] || (cap_flag_q[g] && !capture_flag_clear[g]);
        end
      end
    end
  endgenerate

  assign capture_flag  = cap_flag_q;
  assign capture0_high = cap_q[0][15:8];
  assign capture0_low  = cap_q[0][7:0];
  assign capture1_high = cap_q[1][15:8];
  assign capture1_low  = cap_q[1][7:0];
  assign capture2_high = cap_q[2][15:8];
  assign capture2_low  = cap_q[2][7:0];

  // Unit 3
  logic        u3_run;
  logic        u3_tick;
  logic        u3_step;
  logic        u3_ovf;
  logic [15:0] u3_cnt_q;
  logic [15:0] u3_rld_q;
  logic [15:0] u3_rld_d;
  logic        u3_flag_q;
  logic        u3_tick_q;

  assign u3_run = unit3_control_reg[timer_unit_pkg::U3_RUN_BIT];

  prescale_tick u_u3_prescale (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .run     (u3_run),
    .exp_sel (timer_unit_pkg::U3_PS_EXP[unit3_control_reg[timer_unit_pkg::U3_PS_LSB +: 3]]),
    .tick    (u3_tick)
  );

  assign u3_step  = u3_run && u3_tick;
  assign u3_ovf   = u3_step && (u3_cnt_q == timer_unit_pkg::MAX_COUNT);
  assign u3_rld_d = {unit3_reload_wr.wr_high ? unit3_reload_wr.data : u3_rld_q[15:8],
                     unit3_reload_wr.wr_low  ? unit3_reload_wr.data : u3_rld_q[7:0]};

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      u3_cnt_q  <= timer_unit_pkg::COUNT_RST;
      u3_rld_q  <= timer_unit_pkg::COUNT_RST;
      u3_flag_q <= 1'b0;
      u3_tick_q <= 1'b0;
    end else begin
      u3_cnt_q  <= u3_ovf ? u3_rld_q : (u3_step ? 16'(u3_cnt_q + 16'h0001) : u3_cnt_q);
      u3_rld_q  <= u3_rld_d;
      // flag set; cleared on service entry, set wins
      u3_flag_q <= u3_ovf || (u3_flag_q && !unit3_irq_ack);
      u3_tick_q <= u3_ovf;
    end
  end

  assign unit3_reload_high   = u3_rld_q[15:8];
  assign unit3_reload_low    = u3_rld_q[7:0];
  assign unit3_overflow_flag = u3_flag_q;
  assign unit3_irq_req       = u3_flag_q && extended_irq_enable_reg[timer_unit_pkg::EIE_U3_BIT];
  assign unit3_baud_tick     = u3_tick_q;

endmodule // quad_timer_counter_unit
`default_nettype wire

//--- quad_timer_counter_unit_properties.sv
`timescale 1ns/100ps
`default_nettype none
module quad_timer_counter_unit_checker (
  // Clock and reset
  input wire logic                        ref_clk,
  input wire logic                        nrst,
  // Units 0 and 1
  input wire logic [7:0]                  timer_mode_reg,
  input wire logic [7:0]                  clock_control_reg,
  input wire logic                        unit0_run,
  input wire timer_unit_pkg::byte_write_s unit0_count_wr,
  input wire logic [7:0]                  unit0_count_high,
  input wire logic [7:0]                  unit0_count_low,
  input wire logic                        unit0_overflow_flag,
  input wire logic                        unit0_event_pin_out,
  input wire logic                        unit0_event_pin_oe,
  // Unit 2
  input wire logic [7:0]                  unit2_control_reg,
  input wire logic [2:0]                  unit2_prescale_select,
  input wire timer_unit_pkg::byte_write_s unit2_count_wr,
  input wire timer_unit_pkg::byte_write_s unit2_cmp_reload_wr,
  input wire logic [7:0]                  unit2_count_high,
  input wire logic [7:0]                  unit2_count_low,
  input wire logic [7:0]                  unit2_cmp_reload_high,
  input wire logic [7:0]                  unit2_cmp_reload_low,
  input wire logic                        unit2_overflow_flag,
  // Unit 3
  input wire logic [7:0]                  extended_irq_enable_reg,
  input wire logic                        unit3_irq_ack,
  input wire logic                        unit3_overflow_flag,
  input wire logic                        unit3_irq_req,
  input wire logic                        unit3_baud_tick
);
  wire logic [15:0] c0 = {unit0_count_high, unit0_count_low};
  wire logic [15:0] c2 = {unit2_count_high, unit2_count_low};
  wire logic [15:0] r2 = {unit2_cmp_reload_high, unit2_cmp_reload_low};
  wire logic        w0 = unit0_count_wr.wr_high | unit0_count_wr.wr_low;
  wire logic        w2 = |{unit2_count_wr.wr_high, unit2_count_wr.wr_low, unit2_cmp_reload_wr.wr_high,
                           unit2_cmp_reload_wr.wr_low};

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // Undivided timer tick with no write in the way
  sequence u0_fast;
    unit0_run && clock_control_reg[3] && !timer_mode_reg[2] && !w0;
  endsequence
  // Prescaler already running for a cycle, so this edge ticks
  sequence u2_armed;
    (unit2_control_reg[2] && unit2_prescale_select == 3'h0) [*2];
  endsequence

  chk_u0_write_low: assert property (unit0_count_wr.wr_low |=> unit0_count_low == $past(unit0_count_wr.data))
    else $error("unit0 low byte write lost");
  chk_u0_step: assert property (u0_fast ##0 (c0 != 16'hffff) |=> c0 == $past(c0) + 16'h0001)
    else $error("unit0 count did not advance by one");
  chk_u0_wrap: assert property (u0_fast ##0 (c0 == 16'hffff) |=> c0 == 16'h0000 && unit0_overflow_flag)
    else $error("unit0 wrap without flag");
  chk_u0_toggle: assert property (u0_fast ##0 (c0 == 16'hffff && clock_control_reg[1])
    |=> unit0_event_pin_out != $past(unit0_event_pin_out))
    else $error("unit0 toggle output did not invert");
  chk_u0_oe_follow: assert property (unit0_event_pin_oe == clock_control_reg[1])
    else $error("unit0 pin enable differs from toggle enable");
  chk_u0_idle_high: assert property (!clock_control_reg[1] [*2] |-> unit0_event_pin_out)
    else $error("unit0 toggle output not high while disabled");
  chk_u2_reload: assert property (u2_armed ##0 (unit2_control_reg[0] && c2 == 16'hffff && !w2)
    |=> c2 == $past(r2) && unit2_overflow_flag)
    else $error("unit2 reload missing");
  chk_u2_stopped: assert property (!unit2_control_reg[2] && !w2 |=> $stable(c2))
    else $error("unit2 counted while stopped");
  chk_u3_irq_req: assert property (unit3_irq_req == (unit3_overflow_flag && extended_irq_enable_reg[1]))
    else $error("unit3 request mismatch");
  chk_u3_baud_tick: assert property ($rose(unit3_overflow_flag) |-> unit3_baud_tick)
    else $error("unit3 baud tick missing");
  chk_u3_ack_clear: assert property (unit3_irq_ack |=> (!unit3_overflow_flag || unit3_baud_tick))
    else $error("unit3 flag not cleared by service entry");
endmodule // quad_timer_counter_unit_checker

bind quad_timer_counter_unit quad_timer_counter_unit_checker u_quad_timer_counter_unit_checker (
  .ref_clk, .nrst, .timer_mode_reg, .clock_control_reg, .unit0_run, .unit0_count_wr, .unit0_count_high,
  .unit0_count_low, .unit0_overflow_flag, .unit0_event_pin_out, .unit0_event_pin_oe, .unit2_control_reg,
  .unit2_prescale_select, .unit2_count_wr, .unit2_cmp_reload_wr, .unit2_count_high, .unit2_count_low,
  .unit2_cmp_reload_high, .unit2_cmp_reload_low, .unit2_overflow_flag, .extended_irq_enable_reg,
  .unit3_irq_ack, .unit3_overflow_flag, .unit3_irq_req, .unit3_baud_tick);
`default_nettype wire

//--- quad_timer_counter_unit_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module quad_timer_counter_unit_test;
  logic       ref_clk = 1'b0, nrst = 1'b0, pin1_drv = 1'b1;
  logic [7:0] timer_mode_reg = 8'h00, clock_control_reg = 8'h00, unit2_control_reg = 8'h00;
  logic [7:0] unit3_control_reg = 8'h00, extended_irq_enable_reg = 8'h00;
  logic       unit0_run = 1'b0, unit1_run = 1'b0, unit0_overflow_clear = 1'b0, unit1_overflow_clear = 1'b0;
  logic       unit2_flag_clear = 1'b0, unit3_irq_ack = 1'b0;
  logic [2:0] unit2_prescale_select = 3'h0, capture_pin_in = 3'h7, capture_flag_clear = 3'h0;
  timer_unit_pkg::byte_write_s wr [4] = '{default: '0};
  timer_unit_pkg::byte_write_s unit1_count_wr = '0;
  logic [7:0] unit0_count_high, unit0_count_low, unit1_count_high, unit1_count_low, unit2_count_high;
  logic [7:0] unit2_count_low, unit2_cmp_reload_high, unit2_cmp_reload_low, unit3_reload_high, unit3_reload_low;
  logic [7:0] capture0_high, capture0_low, capture1_high, capture1_low, capture2_high, capture2_low;
  logic       unit0_overflow_flag, unit1_overflow_flag, unit0_event_pin_out, unit0_event_pin_oe;
  logic       unit1_event_pin_out, unit1_event_pin_oe, unit2_overflow_flag, unit2_compare_flag;
  logic       unit3_overflow_flag, unit3_irq_req, unit3_baud_tick;
  logic [2:0] capture_flag;
  int         checks = 0, num_errors = 0, n = 0;
  // Shared pins: the unit drives when enabled, else the bench
  wire logic  unit0_event_pin_in = unit0_event_pin_oe ? unit0_event_pin_out : 1'b1;
  wire logic  unit1_event_pin_in = unit1_event_pin_oe ? unit1_event_pin_out : pin1_drv;
  wire logic [15:0] c0 = {unit0_count_high, unit0_count_low};
  wire logic [15:0] c2 = {unit2_count_high, unit2_count_low};
  wire logic [15:0] cap [3];
  assign cap[0] = {capture0_high, capture0_low};
  assign cap[1] = {capture1_high, capture1_low};
  assign cap[2] = {capture2_high, capture2_low};

  quad_timer_counter_unit u_quad_timer_counter_unit (.*, .unit0_count_wr(wr[0]), .unit2_count_wr(wr[1]),
    .unit2_cmp_reload_wr(wr[2]), .unit3_reload_wr(wr[3]));

  always #5 ref_clk = ~ref_clk;

  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask

  // Byte writes: 0 unit0 count, 1 unit2 count, 2 unit2 compare/reload, 3 unit3 reload
  task automatic wr16(input int k, input logic [15:0] v);
    wr[k] = '{1'b1, 1'b0, v[15:8]};
    cyc(1);
    wr[k] = '{1'b0, 1'b1, v[7:0]};
    cyc(1);
    wr[k] = '0;
    cyc(1);
  endtask

  task automatic give_verdict();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    cyc(4);
    nrst = 1'b1;
    `CHK({c0, c2, cap[0], unit3_reload_low}, 56'h0)
    `CHK({unit0_event_pin_out, unit0_overflow_flag, unit3_irq_req}, 3'b100)
    clock_control_reg = 8'h0a;
    wr16(0, 16'hfffe);
    `CHK({c0, unit0_event_pin_out}, 17'h1fffd)
    unit0_run = 1'b1;
    cyc(2);
    unit0_run = 1'b0;
    `CHK({c0, unit0_overflow_flag, unit0_event_pin_out}, 18'h2)
    unit0_overflow_clear = 1'b1;
    cyc(1);
    unit0_overflow_clear = 1'b0;
    `CHK(unit0_overflow_flag, 1'b0)
    clock_control_reg = 8'h02;
    wr16(0, 16'h0000);
    unit0_run = 1'b1;
    cyc(24);
    unit0_run = 1'b0;
    `CHK(c0, 16'h0002)
    timer_mode_reg = 8'h40;
    unit1_run = 1'b1;
    repeat (3) begin
      pin1_drv = 1'b0;
      cyc(3);
      pin1_drv = 1'b1;
      cyc(3);
    end
    cyc(5);
    unit1_run = 1'b0;
    `CHK({unit1_count_high, unit1_count_low}, 16'h0003)
    `CHK({unit1_overflow_flag, unit1_event_pin_out, unit1_event_pin_oe}, 3'b010)
    for (int i = 0; i < 8; i++) begin
      unit2_prescale_select = 3'(i);
      wr16(1, 16'h0000);
      unit2_control_reg = 8'h04;
      cyc(512);
      unit2_control_reg = 8'h00;
      `CHK(c2, 16'h0200 >> timer_unit_pkg::U2_PS_EXP[i])
    end
    cyc(20);
    `CHK(c2, 16'h0001)
    unit2_flag_clear = 1'b1;
    cyc(1);
    unit2_flag_clear = 1'b0;
    unit2_prescale_select = 3'h0;
    wr16(2, 16'h0005);
    wr16(1, 16'h0000);
    unit2_control_reg = 8'h04;
    cyc(10);
    unit2_control_reg = 8'h00;
    `CHK({c2, unit2_compare_flag}, 17'h00015)
    wr16(2, 16'h1234);
    wr16(1, 16'hfffe);
    unit2_control_reg = 8'h05;
    cyc(2);
    unit2_control_reg = 8'h00;
    `CHK({c2, unit2_overflow_flag}, 17'h02469)
    for (int k = 0; k < 3; k++) begin
      capture_pin_in[k] = 1'b0;
      cyc(6);
      capture_pin_in[k] = 1'b1;
      cyc(3);
      `CHK({cap[k], capture_flag[k]}, 17'h02469)
    end
    capture_flag_clear = 3'h7;
    cyc(1);
    capture_flag_clear = 3'h0;
    `CHK(capture_flag, 3'h0)
    wr16(3, 16'hfffe);
    `CHK({unit3_reload_high, unit3_reload_low}, 16'hfffe)
    extended_irq_enable_reg = 8'h02;
    unit3_control_reg = 8'h08;
    while (unit3_overflow_flag !== 1'b1 && n < 70000) begin
      cyc(1);
      n++;
    end
    `CHK(n, 65536)
    `CHK({unit3_irq_req, unit3_baud_tick}, 2'b11)
    unit3_irq_ack = 1'b1;
    cyc(1);
    unit3_irq_ack = 1'b0;
    `CHK({unit3_overflow_flag, unit3_baud_tick}, 2'b00)
    cyc(1);
    `CHK({unit3_overflow_flag, unit3_baud_tick}, 2'b11)
    extended_irq_enable_reg = 8'h00;
    #1;
    `CHK(unit3_irq_req, 1'b0)
    unit3_control_reg = 8'h00;
    give_verdict();
  end

  // Whole run is near 70000 cycles
  initial begin
    repeat (90000) @(posedge ref_clk);
    num_errors++;
    give_verdict();
  end
endmodule // quad_timer_counter_unit_test
`default_nettype wire

//--- timer_unit_pkg.sv
// Contract
// - Units 0/1: 16-bit count, two byte halves
// - Mode bits 2/6 pick timer or counter
// - Timer ticks: clock/12 or clock, bits 3/4
// - Counter advances on sampled high-then-low
// - Toggle enable inverts event pin on overflow
// - Toggle pin reads 1 before first overflow
// - Unit 2: 16-bit, compare or reload mode
// - Unit 2: three capture channels with results
// - Unit 2 prescaler has eight ratios
// - Unit 2 counts only while run bit 2 set
// - Unit 3: 16-bit reload, prescale bits 2:0
// - Unit 3 runs on bit 3, reload pair
// - Unit 3 rollover sets flag, reloads counter
// - Unit 3 flag with enable requests interrupt
// - Unit 3 flag clears on service entry
// - Unit 3 overflow feeds serial baud clock
package timer_unit_pkg;

  // Byte write strobe with its data
  typedef struct packed {
    logic       wr_high;
    logic       wr_low;
    logic [7:0] data;
  } byte_write_s;

  // Mode register: counter select per unit
  localparam int unsigned MODE_CT_BIT0    = 2;
  localparam int unsigned MODE_CT_BIT1    = 6;
  // Clock control register
  localparam int unsigned CKC_DIVSEL_BIT0 = 3;
  localparam int unsigned CKC_DIVSEL_BIT1 = 4;
  localparam int unsigned CKC_TOGOE_BIT0  = 1;
  localparam int unsigned CKC_TOGOE_BIT1  = 2;
  // Unit 2 control register
  localparam int unsigned U2_CMRL_BIT     = 0;
  localparam int unsigned U2_RUN_BIT      = 2;
  // Unit 3 control register
  localparam int unsigned U3_PS_LSB       = 0;
  localparam int unsigned U3_RUN_BIT      = 3;
  localparam int unsigned U3_FLAG_BIT     = 4;
  // Extended interrupt enable register
  localparam int unsigned EIE_U3_BIT      = 1;

  // Standard timer tick divider
  localparam int unsigned DIV12           = 12;
  localparam logic [3:0]  DIV12_LAST      = 4'(DIV12 - 1);

  // Prescale ratios as power-of-two exponents
  localparam logic [3:0]  U2_PS_EXP [8]   = '{4'h0, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
  localparam logic [3:0]  U3_PS_EXP [8]   = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};

  // Reset and full-scale counts, synchroniser depth and pin count
  localparam logic [15:0] COUNT_RST       = 16'h0000;
  localparam logic [15:0] MAX_COUNT       = 16'hffff;
  localparam int unsigned SYNC_STAGES     = 3;
  localparam int unsigned PIN_COUNT       = 5;

endpackage
